//--- rtl/tmsr_top.sv
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - trigger captures all selected magnitudes
// - setting picks per-unit or primary values
// - setting picks overcurrent or voltage fault type
// - capture in the same cycle as trigger
// - any stage trip latches fault values
// - display shows latched values and fault type
// - fault view only while view enable was set the cycle before
// - latched values cleared only by selected reset
// - keep the twelve latest snapshots readable
// - eight slots, each source individually selectable
// - fault types and stage reported per capture
module tmsr_top #(
  parameter int W = 16,
  parameter int NSRC = 16,
  parameter int NTRIG = 8,
  parameter int NRST = 8,
  parameter int NSTAGE = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NTRIG-1:0] trigIn,
  input wire logic [NRST-1:0] clearIn,
  input wire logic [NSTAGE-1:0] stageTrip,
  input wire logic [tmsr_pkg::FTYPE_W-1:0] ocFaultType,
  input wire logic [tmsr_pkg::FTYPE_W-1:0] voltFaultType,
  input wire logic [NSRC*W-1:0] measPri,
  input wire logic [NSRC*W-1:0] measPu,
  output logic faultViewOn,
  output logic [tmsr_pkg::FTYPE_W-1:0] faultViewType,
  output logic [tmsr_pkg::STAGE_W-1:0] faultViewStage,
  output logic [tmsr_pkg::SNAP_SLOTS*W-1:0] faultViewVal,
  output logic reportValid,
  output logic [tmsr_pkg::FTYPE_W-1:0] reportOcType,
  output logic [tmsr_pkg::FTYPE_W-1:0] reportVoltType,
  output logic [tmsr_pkg::STAGE_W-1:0] reportStage,
  output logic irq
);
  localparam int SLOTS = tmsr_pkg::SNAP_SLOTS;
  localparam int SW = $clog2(NSRC);
  localparam int DW = SLOTS * W + tmsr_pkg::META_W;
  localparam int PW = $clog2(tmsr_pkg::SNAP_DEPTH);
  localparam int FT = tmsr_pkg::FTYPE_W;
  localparam int ST = tmsr_pkg::STAGE_W;

  function automatic logic [ST-1:0] stageOf(input logic [NSTAGE-1:0] v);
    logic [ST-1:0] r;
    r = '0;
    for (int i = NSTAGE - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = ST'(i + 1);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // configuration and bus state
  logic [tmsr_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [31:0] slotSel_q, slotSel_d;
  localparam int IRQ_W_L = tmsr_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
  logic [PW-1:0] rdIdx_q, rdIdx_d;
  logic ack_q, ack_d, irq_q, irq_d;
  logic [31:0] dat_q, dat_d;
  // capture and fault state
  logic [NTRIG-1:0] trigPrev_q;
  logic [NSTAGE-1:0] tripPrev_q;
  logic latched_q, latched_d, view_q, view_d;
  logic [FT-1:0] fType_q, fType_d;
  logic [ST-1:0] fStage_q, fStage_d;
  logic [SLOTS*W-1:0] fVal_q, fVal_d;
  logic repValid_q, repValid_d;
  logic [FT-1:0] repOc_q, repOc_d, repVolt_q, repVolt_d;
  logic [ST-1:0] repStage_q, repStage_d;

  logic puMode, voltMode, viewEn;
  logic trigLvl, trigPrevSel, capEv, clearLvl;
  logic [NSTAGE-1:0] tripRise;
  logic anyTrip;
  logic [SLOTS*W-1:0] capVals;
  logic [FT-1:0] selType;
  logic [ST-1:0] stageNow, stageRise;
  logic [DW-1:0] entry, rdEntry;
  logic [PW:0] fill;
  logic full;
  logic reqNew, wrDo;

  assign puMode = ctrl_q[tmsr_pkg::CTRL_PU_BIT];
  assign voltMode = ctrl_q[tmsr_pkg::CTRL_VOLT_BIT];
  assign viewEn = ctrl_q[tmsr_pkg::CTRL_VIEW_BIT];

  // each slot picks its own source; per-unit or primary set globally
  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    logic [SW-1:0] src;
    assign src = slotSel_q[s*SW +: SW];
    assign capVals[s*W +: W] = puMode ? measPu[int'(src)*W +: W] : measPri[int'(src)*W +: W];
  end

  always_comb begin
    trigLvl = 1'b0;
    trigPrevSel = 1'b0;
    clearLvl = 1'b0;
    for (int i = 0; i < NTRIG; i++) begin
      if (ctrl_q[tmsr_pkg::CTRL_TSEL_LSB +: tmsr_pkg::SEL_W] == tmsr_pkg::SEL_W'(i)) begin
        trigLvl = trigIn[i];
        trigPrevSel = trigPrev_q[i];
      end
    end
    for (int i = 0; i < NRST; i++) begin
      if (ctrl_q[tmsr_pkg::CTRL_RSEL_LSB +: tmsr_pkg::SEL_W] == tmsr_pkg::SEL_W'(i)) begin
        clearLvl = clearIn[i];
      end
    end
  end

  // edge on the selected trigger, captured at this very edge, no delay
  assign capEv = trigLvl & ~trigPrevSel;
  assign tripRise = stageTrip & ~tripPrev_q;
  assign anyTrip = |tripRise;
  assign selType = voltMode ? voltFaultType : ocFaultType;
  assign stageNow = stageOf(stageTrip);
  assign stageRise = stageOf(tripRise);
  assign entry = {voltMode, puMode, selType, stageNow, capVals};

  tmsr_snap_mem #(
    .DEPTH(tmsr_pkg::SNAP_DEPTH),
    .DW(DW)
  ) u_mem (
    .core_clk(core_clk),
    .rst(rst),
    .wrEn(capEv),
    .wrData(entry),
    .rdAge(rdIdx_q),
    .rdData(rdEntry),
    .fill(fill),
    .full(full)
  );

  // fault register and supervisory report
  always_comb begin
    latched_d = latched_q;
    fType_d = fType_q;
    fStage_d = fStage_q;
    fVal_d = fVal_q;
    if (clearLvl) begin
      latched_d = 1'b0;
      fVal_d = '0;
    end
    // a trip in the same cycle as a clear wins, so it is never lost
    if (anyTrip) begin
      latched_d = 1'b1;
      fType_d = selType;
      fStage_d = stageRise;
      fVal_d = capVals;
    end
    view_d = latched_d & viewEn;
    repValid_d = capEv;
    repOc_d = capEv ? ocFaultType : repOc_q;
    repVolt_d = capEv ? voltFaultType : repVolt_q;
    repStage_d = capEv ? stageNow : repStage_q;
  end

  // wishbone slave: ack one cycle after the request, write at the ack edge
  assign reqNew = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wrDo = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;

  always_comb begin
    logic [31:0] ctrlWord;
    logic [31:0] ctrlNew;
    ctrlWord = 32'(ctrl_q);
    ctrlNew = ctrlWord;
    ack_d = reqNew;
    dat_d = dat_q;
    ctrl_d = ctrl_q;
    slotSel_d = slotSel_q;
    irqMask_d = irqMask_q;
    rdIdx_d = rdIdx_q;
    irqStat_d = irqStat_q;
    if (reqNew && !wb_we_i) begin
      dat_d = 32'h0;
      if (wb_adr_i >= tmsr_pkg::OFS_SNAP_VAL && wb_adr_i < tmsr_pkg::OFS_FAULT_VAL) begin
        dat_d = 32'(rdEntry[int'(wb_adr_i[4:2])*W +: W]);
      end else if (wb_adr_i >= tmsr_pkg::OFS_FAULT_VAL && wb_adr_i < 8'h80) begin
        dat_d = 32'(fVal_q[int'(wb_adr_i[4:2])*W +: W]);
      end else begin
        unique case (wb_adr_i)
          tmsr_pkg::OFS_CTRL: dat_d = ctrlWord;
          tmsr_pkg::OFS_SLOT_SEL: dat_d = slotSel_q;
          tmsr_pkg::OFS_STATUS: begin
            dat_d[tmsr_pkg::STAT_FILL_LSB +: PW+1] = fill;
            dat_d[tmsr_pkg::STAT_LATCH_BIT] = latched_q;
            dat_d[tmsr_pkg::STAT_VIEW_BIT] = view_q;
            dat_d[tmsr_pkg::STAT_TYPE_LSB +: FT] = fType_q;
            dat_d[tmsr_pkg::STAT_STAGE_LSB +: ST] = fStage_q;
          end
          tmsr_pkg::OFS_IRQ_STAT: dat_d = 32'(irqStat_q);
          tmsr_pkg::OFS_IRQ_MASK: dat_d = 32'(irqMask_q);
          tmsr_pkg::OFS_RD_IDX: dat_d = 32'(rdIdx_q);
          tmsr_pkg::OFS_RD_META: dat_d = 32'(rdEntry[DW-1 -: tmsr_pkg::META_W]);
          default: dat_d = 32'h0;
        endcase
      end
    end
    if (wrDo) begin
      unique case (wb_adr_i)
        tmsr_pkg::OFS_CTRL: begin
          ctrlNew = laneMerge(ctrlWord, wb_dat_i, wb_sel_i);
          ctrl_d = ctrlNew[tmsr_pkg::CTRL_W-1:0];
        end
        tmsr_pkg::OFS_SLOT_SEL: slotSel_d = laneMerge(slotSel_q, wb_dat_i, wb_sel_i);
        tmsr_pkg::OFS_IRQ_STAT: if (wb_sel_i[0]) irqStat_d = irqStat_q & ~wb_dat_i[IRQ_W_L-1:0];
        tmsr_pkg::OFS_IRQ_MASK: if (wb_sel_i[0]) irqMask_d = wb_dat_i[IRQ_W_L-1:0];
        tmsr_pkg::OFS_RD_IDX: if (wb_sel_i[0]) rdIdx_d = wb_dat_i[PW-1:0];
        default: ;
      endcase
    end
    // events are applied after the clear so that they win
    if (capEv) irqStat_d[tmsr_pkg::IRQ_CAPTURE] = 1'b1;
    if (anyTrip) irqStat_d[tmsr_pkg::IRQ_TRIP] = 1'b1;
    if (capEv && full) irqStat_d[tmsr_pkg::IRQ_OVERWRITE] = 1'b1;
    irq_d = |(irqStat_d & irqMask_d);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= tmsr_pkg::CTRL_RESET;
      slotSel_q <= tmsr_pkg::SLOT_SEL_RESET;
      irqStat_q <= '0;
      irqMask_q <= tmsr_pkg::IRQ_MASK_RESET;
      rdIdx_q <= '0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      irq_q <= 1'b0;
      trigPrev_q <= '0;
      tripPrev_q <= '0;
      latched_q <= 1'b0;
      view_q <= 1'b0;
      fType_q <= '0;
      fStage_q <= '0;
      fVal_q <= '0;
      repValid_q <= 1'b0;
      repOc_q <= '0;
      repVolt_q <= '0;
      repStage_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      slotSel_q <= slotSel_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      rdIdx_q <= rdIdx_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_q <= irq_d;
      trigPrev_q <= trigIn;
      tripPrev_q <= stageTrip;
      latched_q <= latched_d;
      view_q <= view_d;
      fType_q <= fType_d;
      fStage_q <= fStage_d;
      fVal_q <= fVal_d;
      repValid_q <= repValid_d;
      repOc_q <= repOc_d;
      repVolt_q <= repVolt_d;
      repStage_q <= repStage_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign irq = irq_q;
  assign faultViewOn = view_q;
  assign faultViewType = fType_q;
  assign faultViewStage = fStage_q;
  assign faultViewVal = fVal_q;
  assign reportValid = repValid_q;
  assign reportOcType = repOc_q;
  assign reportVoltType = repVolt_q;
  assign reportStage = repStage_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ack_single_a: assert property (ack_q |=> !ack_q) else $error("ack held two cycles");
  cap_fill_a: assert property (capEv && !full |=> fill == $past(fill) + 1'b1) else $error("capture not stored");
  cap_same_a: assert property (capEv |=> u_mem.mem[$past(u_mem.wrPtr_q)] == $past(entry))
    else $error("capture delayed");
  cap_rep_a: assert property (capEv |=> reportValid && reportStage == $past(stageNow)
    && reportOcType == $past(ocFaultType) && reportVoltType == $past(voltFaultType)) else $error("report wrong");
  pu_pick_a: assert property (capEv |-> entry[W-1:0] == (puMode ? measPu[int'(slotSel_q[SW-1:0])*W +: W]
    : measPri[int'(slotSel_q[SW-1:0])*W +: W])) else $error("value representation wrong");
  type_pick_a: assert property (capEv |-> entry[DW-3 -: FT] == (voltMode ? voltFaultType : ocFaultType))
    else $error("fault type wrong");
  trip_latch_a: assert property (anyTrip |=> latched_q && fVal_q == $past(capVals)) else $error("trip not latched");
  latch_hold_a: assert property (latched_q && !clearLvl && !anyTrip |=> latched_q && $stable(fVal_q))
    else $error("fault values lost");
  view_gate_a: assert property (!viewEn [*2] |-> !faultViewOn) else $error("view raised while disabled");
  // a trip wins over a clear in its own cycle, so the view must follow at the next edge
  view_show_a: assert property (anyTrip && viewEn |=> faultViewOn && faultViewType == $past(selType)
    && faultViewStage == $past(stageRise)) else $error("fault view missing");
  fill_cap_a: assert property (full && capEv |=> fill == $past(fill) && irqStat_q[tmsr_pkg::IRQ_OVERWRITE])
    else $error("overwrite wrong");
  fill_max_a: assert property (int'(fill) <= tmsr_pkg::SNAP_DEPTH) else $error("fill above depth");

  cap_seen_c: cover property (capEv ##1 reportValid);
  view_seen_c: cover property (anyTrip ##2 faultViewOn);
  wrap_seen_c: cover property (full && capEv);
  clear_seen_c: cover property (latched_q && clearLvl ##1 !latched_q);
endmodule

//--- rtl/tmsr_pkg.sv
package tmsr_pkg;
  // storage shape
  localparam int SNAP_DEPTH = 12;
  localparam int SNAP_SLOTS = 8;
  localparam int STAGE_W = 4;
  localparam int FTYPE_W = 4;
  localparam int META_W = 2 + FTYPE_W + STAGE_W;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLOT_SEL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_RD_IDX = 8'h14;
  localparam logic [7:0] OFS_RD_META = 8'h18;
  localparam logic [7:0] OFS_SNAP_VAL = 8'h40;
  localparam logic [7:0] OFS_FAULT_VAL = 8'h60;

  // control register fields
  localparam int CTRL_PU_BIT = 0;
  localparam int CTRL_VOLT_BIT = 1;
  localparam int CTRL_VIEW_BIT = 2;
  localparam int CTRL_TSEL_LSB = 4;
  localparam int CTRL_RSEL_LSB = 8;
  localparam int SEL_W = 4;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam logic [31:0] SLOT_SEL_RESET = 32'h76543210;

  // status register fields
  localparam int STAT_FILL_LSB = 0;
  localparam int STAT_LATCH_BIT = 8;
  localparam int STAT_VIEW_BIT = 9;
  localparam int STAT_TYPE_LSB = 12;
  localparam int STAT_STAGE_LSB = 16;

  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_OVERWRITE = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
endpackage

//--- rtl/tmsr_snap_mem.sv
`timescale 1ns/1ps
module tmsr_snap_mem #(
  parameter int DEPTH = 12,
  parameter int DW = 138
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [DW-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAge,
  output logic [DW-1:0] rdData,
  output logic [$clog2(DEPTH):0] fill,
  output logic full
);
  localparam int PW = $clog2(DEPTH);

  // entries carry no reset; the fill count masks ones never written
  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q, wrPtr_d;
  logic [PW:0] fill_q, fill_d;
  int rdPos;

  always_comb begin
    wrPtr_d = wrPtr_q;
    fill_d = fill_q;
    if (wrEn) begin
      // ring pointer: when full the oldest entry is the one overwritten
      wrPtr_d = (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (fill_q != (PW+1)'(DEPTH)) begin
        fill_d = fill_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      fill_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      fill_q <= fill_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrPtr_q] <= wrData;
    end
  end

  // age 0 is the newest entry
  always_comb begin
    rdPos = int'(wrPtr_q) + DEPTH - 1 - int'(rdAge);
    if (rdPos >= DEPTH) begin
      rdPos = rdPos - DEPTH;
    end
    rdData = (int'(rdAge) < int'(fill_q)) ? mem[rdPos[PW-1:0]] : '0;
  end

  assign fill = fill_q;
  assign full = (fill_q == (PW+1)'(DEPTH));
endmodule

//--- dv/tmsr_meas_model.sv
`timescale 1ns/1ps
module tmsr_meas_model #(
  parameter int W = 16,
  parameter int NSRC = 16
) (
  input wire logic [7:0] base,
  output logic [NSRC*W-1:0] measPri,
  output logic [NSRC*W-1:0] measPu,
  output logic [tmsr_pkg::FTYPE_W-1:0] ocFaultType,
  output logic [tmsr_pkg::FTYPE_W-1:0] voltFaultType
);
  // every source carries its own index so a wrong slot mapping cannot pass
  always_comb begin
    for (int k = 0; k < NSRC; k++) begin
      measPri[k*W +: W] = {base, 8'(k)};
      measPu[k*W +: W] = {8'(k), ~base};
    end
    ocFaultType = base[3:0];
    voltFaultType = base[7:4];
  end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [7:0] base = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, junk;
  logic ack, viewOn, repValid, irq;
  logic [7:0] trigIn = 8'h00;
  logic [7:0] clearIn = 8'h00;
  logic [14:0] stageTrip = 15'h0;
  logic [3:0] ocType, voltType, viewType, viewStage, repOc, repVolt, repStage;
  logic [255:0] measPri, measPu;
  logic [127:0] viewVal;
  logic [31:0] slotSel = 32'h9f3a5c81;
  int fails = 0;
  int compares = 0;

  always #20 core_clk = ~core_clk;

  tmsr_meas_model u_tmsr_meas_model (.base(base), .measPri(measPri), .measPu(measPu),
    .ocFaultType(ocType), .voltFaultType(voltType));

  tmsr_top u_tmsr_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .trigIn(trigIn), .clearIn(clearIn), .stageTrip(stageTrip),
    .ocFaultType(ocType), .voltFaultType(voltType), .measPri(measPri), .measPu(measPu),
    .faultViewOn(viewOn), .faultViewType(viewType), .faultViewStage(viewStage),
    .faultViewVal(viewVal), .reportValid(repValid), .reportOcType(repOc),
    .reportVoltType(repVolt), .reportStage(repStage), .irq(irq));

  task automatic conclude;
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    junk = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk(junk, e);
  endtask

  // capture on trigger source 2; the values move right after the capture edge
  task automatic trig(input logic [7:0] b, input logic [3:0] stg);
    @(posedge core_clk);
    trigIn[2] <= 1'b1;
    base <= b;
    @(posedge core_clk);
    base <= ~b;
    #1;
    chk(repValid, 1'b1);
    chk({repStage, repVolt, repOc}, {stg, b[7:4], b[3:0]});
    @(posedge core_clk);
    trigIn[2] <= 1'b0;
    #1;
    chk(repValid, 1'b0);
  endtask

  task automatic slots(input logic pu, input logic [7:0] b);
    logic [3:0] n;
    for (int k = 0; k < 8; k++) begin
      n = slotSel[4*k +: 4];
      rd(8'(tmsr_pkg::OFS_SNAP_VAL + 4*k), pu ? {20'h0, n, ~b} : {16'h0, b, 4'h0, n});
    end
  endtask

  task automatic t_regs;
    rd(tmsr_pkg::OFS_CTRL, 32'h0);
    rd(tmsr_pkg::OFS_SLOT_SEL, 32'h76543210);
    rd(tmsr_pkg::OFS_IRQ_MASK, 32'h0);
    rd(tmsr_pkg::OFS_STATUS, 32'h0);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    wr(tmsr_pkg::OFS_SLOT_SEL, slotSel);
    rd(tmsr_pkg::OFS_SLOT_SEL, slotSel);
  endtask

  task automatic t_capture;
    wr(tmsr_pkg::OFS_CTRL, 32'h020);
    trig(8'h5a, 4'h0);
    wr(tmsr_pkg::OFS_RD_IDX, 32'h0);
    slots(1'b0, 8'h5a);
    rd(tmsr_pkg::OFS_RD_META, 32'h0a0);
    wr(tmsr_pkg::OFS_CTRL, 32'h021);
    trig(8'hc3, 4'h0);
    slots(1'b1, 8'hc3);
    rd(tmsr_pkg::OFS_RD_META, 32'h130);
    wr(tmsr_pkg::OFS_CTRL, 32'h022);
    trig(8'h96, 4'h0);
    rd(tmsr_pkg::OFS_RD_META, 32'h290);
  endtask

  // three entries stored so far; ten more pass the depth by one
  task automatic t_ring;
    for (int i = 0; i < 10; i++) begin
      trig(8'h10 + 8'(i), 4'h0);
      if (i == 8) rd(tmsr_pkg::OFS_IRQ_STAT, 32'h1);
    end
    rd(tmsr_pkg::OFS_STATUS, 32'h0c);
    rd(tmsr_pkg::OFS_IRQ_STAT, 32'h5);
    rd(tmsr_pkg::OFS_SNAP_VAL, 32'h1901);
    wr(tmsr_pkg::OFS_RD_IDX, 32'd11);
    rd(tmsr_pkg::OFS_SNAP_VAL, 32'h013c);
  endtask

  task automatic t_trip;
    wr(tmsr_pkg::OFS_CTRL, 32'h320);
    @(posedge core_clk);
    base <= 8'h77;
    stageTrip[4] <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(viewOn, 1'b0);
    rd(tmsr_pkg::OFS_STATUS, 32'h5710c);
    wr(tmsr_pkg::OFS_CTRL, 32'h324);
    @(posedge core_clk);
    #1;
    chk({viewOn, viewStage, viewType, viewVal[15:0]}, {1'b1, 4'h5, 4'h7, 16'h7701});
    rd(8'(tmsr_pkg::OFS_FAULT_VAL + 4), 32'h7708);
    trig(8'h3e, 4'h5);
    chk(viewVal[15:0], 16'h7701);
    @(posedge core_clk);
    clearIn <= 8'h04;
    repeat (2) @(posedge core_clk);
    #1;
    chk(viewOn, 1'b1);
    @(posedge core_clk);
    clearIn <= 8'h08;
    repeat (2) @(posedge core_clk);
    #1;
    chk(viewOn, 1'b0);
    @(posedge core_clk);
    clearIn <= 8'h00;
    stageTrip <= 15'h0;
  endtask

  task automatic irqchk(input logic e);
    @(posedge core_clk);
    #1;
    chk(irq, e);
  endtask

  task automatic t_irq;
    rd(tmsr_pkg::OFS_IRQ_STAT, 32'h7);
    irqchk(1'b0);
    wr(tmsr_pkg::OFS_IRQ_MASK, 32'h2);
    irqchk(1'b1);
    wr(tmsr_pkg::OFS_IRQ_STAT, 32'h2);
    irqchk(1'b0);
    rd(tmsr_pkg::OFS_IRQ_STAT, 32'h5);
    wr(tmsr_pkg::OFS_IRQ_MASK, 32'h1);
    irqchk(1'b1);
    wr(tmsr_pkg::OFS_IRQ_MASK, 32'h0);
    irqchk(1'b0);
  endtask

  // whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    conclude;
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_capture;
    t_ring;
    t_trip;
    t_irq;
    conclude;
  end
endmodule
